// ===== bench/ecp_host_model.sv
`timescale 1ns/1ps

// ****
// Host side of the static control pins
// ****
module ecp_host_model (
    input wire logic ref_clk,
    input wire logic pinMode,
    input wire logic lineEchoChg,
    input wire logic acEchoChg,
    input wire ecp_pkg::ecp_chan_pins_s lineReq,
    input wire ecp_pkg::ecp_chan_pins_s acReq,
    input wire ecp_pkg::ecp_misc_pins_s miscReq,
    output ecp_pkg::ecp_chan_pins_s linePins,
    output ecp_pkg::ecp_chan_pins_s acousticPins,
    output ecp_pkg::ecp_misc_pins_s miscPins
);
    import ecp_pkg::*;
    localparam ecp_chan_pins_s PARK = '{coef1ClearN: 1'b1, coef2ClearN: 1'b1, default: '0};
    // Test and reserved detect pins never reach the block, held low all the same
    logic [8:0] tiedLow;
    assign tiedLow = 9'h000;

    function automatic ecp_chan_pins_s chan(input logic chg, input ecp_chan_pins_s r);
        ecp_chan_pins_s v;
        v = pinMode ? r : PARK;
        // A new echo path spoils both sets, so both are cleared together
        if (chg)
        begin
            v.coef1ClearN = 1'b0;
            v.coef2ClearN = 1'b0;
        end
        return v;
    endfunction : chan

    initial
    begin
        linePins = PARK;
        acousticPins = PARK;
        miscPins = '0;
    end

    // Pins move only just after a rising edge, like a registered host port
    always @(posedge ref_clk)
    begin
        linePins <= chan(lineEchoChg, lineReq);
        acousticPins <= chan(acEchoChg, acReq);
        miscPins <= pinMode ? miscReq : '0;
    end
endmodule : ecp_host_model

// ===== bench/ecp_pin_control_bench.sv
`timescale 1ns/1ps

// ****
// Bench for the pin control block
// ****
module ecp_pin_control_bench;
    import ecp_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = '0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic frameSync = 1'b0;
    ecp_chan_pins_s linePins;
    ecp_chan_pins_s acousticPins;
    ecp_misc_pins_s miscPins;
    ecp_chan_smp_s lineSmp = '0;
    ecp_chan_smp_s acousticSmp = '0;
    logic [15:0] acousticPcmIn = '0;
    ecp_chan_ctl_s lineCtl;
    ecp_chan_ctl_s acousticCtl;
    logic muteActive;
    logic [2:0] muteLevel;
    logic txVoiceActiveOut;
    logic [15:0] rxPathOut;
    logic pinMode = 1'b0;
    logic lineEchoChg = 1'b0;
    logic acEchoChg = 1'b0;
    ecp_chan_pins_s lineReq = '0;
    ecp_chan_pins_s acReq = '0;
    ecp_misc_pins_s miscReq = '0;
    logic [15:0] voxThr [4] = '{VOX_THR_0, VOX_THR_1, VOX_THR_2, VOX_THR_3};
    logic [15:0] sIn [4] = '{16'h0000, 16'h0041, 16'h0000, 16'h0100};
    logic [15:0] rIn [4] = '{16'h0000, 16'h0000, 16'h7fff, 16'h016e};
    logic [4:0] gainHd [4] = '{5'h00, 5'h00, 5'h11, 5'h00};
    logic [15:0] sOut [8] = '{16'h0008, 16'h0009, 16'hfff8, 16'hfff7,
        16'h0000, 16'hfffc, 16'h7fff, 16'h8000};
    int failCount = 0;
    int nCompared = 0;
    ecp_chan_pins_s p;
    ecp_chan_smp_s s;
    logic [31:0] rd;

    always #4 ref_clk = ~ref_clk;

    ecp_pin_control dut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .frameSync(frameSync),
        .linePins(linePins), .acousticPins(acousticPins), .miscPins(miscPins),
        .lineSmp(lineSmp), .acousticSmp(acousticSmp), .acousticPcmIn(acousticPcmIn),
        .lineCtl(lineCtl), .acousticCtl(acousticCtl), .muteActive(muteActive),
        .muteLevel(muteLevel), .txVoiceActiveOut(txVoiceActiveOut), .rxPathOut(rxPathOut));

    ecp_host_model host (.ref_clk(ref_clk), .pinMode(pinMode), .lineEchoChg(lineEchoChg),
        .acEchoChg(acEchoChg), .lineReq(lineReq), .acReq(acReq), .miscReq(miscReq),
        .linePins(linePins), .acousticPins(acousticPins), .miscPins(miscPins));

    // ****
    // Helpers
    // ****
    task automatic check(input string what, input logic [63:0] e, input logic [63:0] g);
        nCompared++;
        if (g !== e)
        begin
            failCount++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic giveVerdict();
        $display("compared %0d mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : giveVerdict

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] v);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        v = hrdata;
    endtask : bus

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        check("register", 64'(e), 64'(v));
    endtask : rd_chk

    task automatic set_pins(input ecp_chan_pins_s l, input ecp_chan_pins_s a,
        input ecp_misc_pins_s m);
        @(posedge ref_clk);
        pinMode <= 1'b1;
        lineReq <= l;
        acReq <= a;
        miscReq <= m;
    endtask : set_pins

    // Pins have settled for four cycles before the frame, outputs read mid-cycle after it
    task automatic frame(input ecp_chan_smp_s l, input ecp_chan_smp_s a, input logic [15:0] pcm);
        repeat (4) @(posedge ref_clk);
        frameSync <= 1'b1;
        lineSmp <= l;
        acousticSmp <= a;
        acousticPcmIn <= pcm;
        @(posedge ref_clk);
        frameSync <= 1'b0;
        @(negedge ref_clk);
    endtask : frame

    function automatic ecp_chan_pins_s mkp(input logic [2:0] i);
        ecp_chan_pins_s q;
        q = '{i[0], i[1], i[2], ~i[0], ~i[1], i[2], ~i[2] | i[0], i, ~i};
        return q;
    endfunction : mkp

    function automatic logic [15:0] mag(input logic [15:0] x);
        return x[15] ? -x : x;
    endfunction : mag

    function automatic ecp_chan_ctl_s exp_ctl(input ecp_chan_pins_s q, input ecp_chan_smp_s m,
        input logic [4:0] g);
        ecp_chan_ctl_s c;
        logic sp;
        logic rp;
        c = '0;
        sp = mag(m.sendInput) > SIG_PRESENT_LIN;
        rp = mag(m.receiveInput) > SIG_PRESENT_LIN;
        c.coef1Clear = ~q.coef1ClearN;
        c.coef2Clear = ~q.coef2ClearN;
        c.howlDetect = q.howlDetectEn;
        c.coefFreeze = q.coefFreeze;
        c.sendAtten = ~q.attenOff & rp & ~sp;
        c.recvAtten = ~q.attenOff & sp;
        c.gainAttenHalfDb = q.gainCtrlEn ? g : 5'h00;
        c.outGainDb = {q.outGainPad, 1'b0};
        c.inLossDb = {q.inLossPad, 1'b0};
        c.sendOutClipped = (q.centerClipEn && mag(m.sendOutput) <= CLIP_THRESH_LIN) ?
            CLIP_MIN_POS : m.sendOutput;
        return c;
    endfunction : exp_ctl

    // ****
    // Tests
    // ****
    initial
    begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        @(negedge ref_clk);
        check("hreadyout", 64'(1'b1), 64'(hreadyout));
        check("hresp", 64'h0, 64'(hresp));
        check("lineCtl", 64'h0, 64'(lineCtl));
        for (int a = 0; a < 16; a += 4) rd_chk(8'(a), 32'h0);
        bus(1'b1, 8'h0c, 32'hffffffff, rd);
        bus(1'b1, VOICE_ACTIVITY_STATUS_OFS, 32'hffffffff, rd);
        rd_chk(8'h0c, 32'h0);
        rd_chk(VOICE_ACTIVITY_STATUS_OFS, 32'h0);
        frame('0, '0, 16'h0000);
        p = '{coef1ClearN: 1'b1, coef2ClearN: 1'b1, default: '0};
        check("lineCtl", 64'(exp_ctl(p, '0, 5'h00)), 64'(lineCtl));
        check("acousticCtl", 64'(exp_ctl(p, '0, 5'h00)), 64'(acousticCtl));
        for (int i = 0; i < 8; i++)
        begin
            set_pins(mkp(3'(i)), mkp(3'(7 - i)), '0);
            s = '{sIn[i % 4], rIn[i % 4], sOut[i]};
            frame(s, s, 16'h0000);
            check("lineCtl", 64'(exp_ctl(mkp(3'(i)), s, gainHd[i % 4])), 64'(lineCtl));
            check("acousticCtl", 64'(exp_ctl(mkp(3'(7 - i)), s, gainHd[i % 4])),
                64'(acousticCtl));
        end
        set_pins(mkp(3'h0), mkp(3'h0), '0);
        repeat (6) @(negedge ref_clk);
        check("lineCtl", 64'(exp_ctl(mkp(3'h7), s, 5'h00)), 64'(lineCtl));
        frame(s, s, 16'h0000);
        check("lineCtl", 64'(exp_ctl(mkp(3'h0), s, 5'h00)), 64'(lineCtl));
        set_pins(mkp(3'h7), mkp(3'h7), '0);
        lineEchoChg <= 1'b1;
        p = mkp(3'h7);
        p.coef1ClearN = 1'b0;
        p.coef2ClearN = 1'b0;
        frame(s, s, 16'h0000);
        check("lineCtl", 64'(exp_ctl(p, s, 5'h00)), 64'(lineCtl));
        check("acousticCtl", 64'(exp_ctl(mkp(3'h7), s, 5'h00)), 64'(acousticCtl));
        @(posedge ref_clk);
        lineEchoChg <= 1'b0;
        bus(1'b1, MUTE_CONFIG_OFS, 32'h4, rd);
        rd_chk(MUTE_CONFIG_OFS, 32'h4);
        set_pins(mkp(3'h7), mkp(3'h7), '{1'b1, 3'b001, 1'b1});
        frame(s, s, 16'h4000);
        check("muteActive", 64'h1, 64'(muteActive));
        check("muteLevel", 64'h5, 64'(muteLevel));
        check("rxPathOut", 64'h4000, 64'(rxPathOut));
        // Mute register bits cleared before the enable pin drops and the level falls to zero
        bus(1'b1, MUTE_CONFIG_OFS, 32'h0, rd);
        // Loudest noise setting; rx voice bit stays low so noise is chosen
        bus(1'b1, VOICE_ACTIVITY_CONFIG_OFS, 32'he7, rd);
        rd_chk(VOICE_ACTIVITY_CONFIG_OFS, 32'he7);
        set_pins(mkp(3'h7), mkp(3'h7), '{1'b0, 3'b001, 1'b0});
        frame(s, s, 16'h4000);
        check("muteActive", 64'h0, 64'(muteActive));
        check("muteLevel", 64'h0, 64'(muteLevel));
        check("noise", 64'h1, 64'(rxPathOut != 16'h4000));
        bus(1'b1, VOICE_ACTIVITY_CONFIG_OFS, 32'h8, rd);
        frame(s, s, 16'h4000);
        check("rxPathOut", 64'h4000, 64'(rxPathOut));
        for (int t = 0; t < 4; t++)
        begin
            bus(1'b1, VOICE_ACTIVITY_CONFIG_OFS, {24'h0, 1'b1, 2'(t), 5'h00}, rd);
            s = '{voxThr[t], 16'h0000, 16'h0000};
            frame(s, '0, 16'h0000);
            check("txVoiceActiveOut", 64'h0, 64'(txVoiceActiveOut));
            s.sendInput = -(voxThr[t] + 16'h0001);
            frame(s, '0, 16'h0000);
            check("txVoiceActiveOut", 64'h1, 64'(txVoiceActiveOut));
            rd_chk(VOICE_ACTIVITY_STATUS_OFS, 32'h80);
        end
        bus(1'b1, VOICE_ACTIVITY_CONFIG_OFS, 32'h0, rd);
        frame(s, '0, 16'h0000);
        check("txVoiceActiveOut", 64'h0, 64'(txVoiceActiveOut));
        rd_chk(VOICE_ACTIVITY_STATUS_OFS, 32'h80);
        giveVerdict();
    end

    initial
    begin
        repeat (5000) @(posedge ref_clk);
        failCount++;
        $display("watchdog expired before the tests ended");
        giveVerdict();
    end
endmodule : ecp_pin_control_bench

// ===== hw/ecp_pin_control.sv
`timescale 1ns/1ps

// Summary of operation
// - Coefficient set one of a canceller is cleared while its clear pin is low.
// - Coefficient set two of a canceller is cleared while its clear pin is low.
// - Howling detection follows the high level of its enable pin.
// - Center clip forces send output to minimum positive code at or below threshold.
// - Coefficients freeze while the freeze pin is high.
// - Attenuation on and receive-only signal: send attenuator applied.
// - Attenuation on and send signal present: receive attenuator applied instead.
// - Gain control attenuates receive level zero to 8.5 dB above onset.
// - Receive mute level applies only while mute enable pin is high.
// - Mute level pins are ORed with the mute config register bits.
// - Send output gain pad is code times 2 dB.
// - Send input loss pad is code times 2 dB.
// - Transmit voice activity output valid only with its enable bit set.
// - Line transmit input level drives voice activity high for voice.
// - Voice activity result is readable in the status register.
// - Voice detect threshold comes from a two-bit register field.
// - Receive voice high passes acoustic input, low outputs background noise.
// - Receive voice pin is ORed with its register bit.
module ecp_pin_control (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic frameSync,
    input wire ecp_pkg::ecp_chan_pins_s linePins,
    input wire ecp_pkg::ecp_chan_pins_s acousticPins,
    input wire ecp_pkg::ecp_misc_pins_s miscPins,
    input wire ecp_pkg::ecp_chan_smp_s lineSmp,
    input wire ecp_pkg::ecp_chan_smp_s acousticSmp,
    input wire logic [15:0] acousticPcmIn,
    output ecp_pkg::ecp_chan_ctl_s lineCtl,
    output ecp_pkg::ecp_chan_ctl_s acousticCtl,
    output logic muteActive,
    output logic [2:0] muteLevel,
    output logic txVoiceActiveOut,
    output logic [15:0] rxPathOut
);
    import ecp_pkg::*;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [15:0] magOf(input logic [15:0] s);
        if (s == 16'h8000)
        begin
            magOf = 16'h7fff;
        end
        else
        begin
            magOf = s[15] ? (~s + 16'h0001) : s;
        end
    endfunction : magOf

    function automatic logic [3:0] msbIndex(input logic [15:0] m);
        msbIndex = 4'h0;
        for (int i = 0; i < 16; i++)
        begin
            if (m[i])
            begin
                msbIndex = 4'(i);
            end
        end
    endfunction : msbIndex

    // Coarse 2:1 compressor on the octave of the level; enough for loop stability
    function automatic logic [4:0] gcAtten(input logic [15:0] m);
        logic [7:0] prod;
        prod = 8'h00;
        if (m >= GC_ONSET_LIN)
        begin
            prod = 8'({4'h0, msbIndex(m) - GC_ONSET_IDX} * GC_HALFDB_PER_OCT);
        end
        gcAtten = (prod > GC_MAX_HALFDB) ? GC_MAX_HALFDB[4:0] : prod[4:0];
    endfunction : gcAtten

    function automatic logic [15:0] voxThresh(input logic [1:0] sel);
        case (sel)
            2'h0: voxThresh = VOX_THR_0;
            2'h1: voxThresh = VOX_THR_1;
            2'h2: voxThresh = VOX_THR_2;
            default: voxThresh = VOX_THR_3;
        endcase
    endfunction : voxThresh

    function automatic ecp_chan_ctl_s chanCtl(input ecp_chan_pins_s p, input ecp_chan_smp_s s);
        logic sendPresent;
        logic recvPresent;
        chanCtl = '0;
        sendPresent = magOf(s.sendInput) > SIG_PRESENT_LIN;
        recvPresent = magOf(s.receiveInput) > SIG_PRESENT_LIN;
        chanCtl.coef1Clear = !p.coef1ClearN;
        chanCtl.coef2Clear = !p.coef2ClearN;
        chanCtl.howlDetect = p.howlDetectEn;
        chanCtl.coefFreeze = p.coefFreeze;
        chanCtl.sendAtten = !p.attenOff && recvPresent && !sendPresent;
        chanCtl.recvAtten = !p.attenOff && sendPresent;
        chanCtl.gainAttenHalfDb = p.gainCtrlEn ? gcAtten(magOf(s.receiveInput)) : 5'h00;
        chanCtl.outGainDb = {p.outGainPad, 1'b0};
        chanCtl.inLossDb = {p.inLossPad, 1'b0};
        if (p.centerClipEn && magOf(s.sendOutput) <= CLIP_THRESH_LIN)
        begin
            chanCtl.sendOutClipped = CLIP_MIN_POS;
        end
        else
        begin
            chanCtl.sendOutClipped = s.sendOutput;
        end
    endfunction : chanCtl

    function automatic logic [31:0] readMux(input logic [7:0] a, input ecp_state_s s);
        readMux = 32'h0000_0000;
        case (a)
            MUTE_CONFIG_OFS: readMux[MC_LEVEL_LSB +: 3] = s.muteCfg;
            VOICE_ACTIVITY_CONFIG_OFS:
            begin
                readMux[VC_VOX_EN_BIT] = s.vcfg.voxEn;
                readMux[VC_THR_LSB +: 2] = s.vcfg.voxThrSel;
                readMux[VC_RX_VOICE_BIT] = s.vcfg.rxVoice;
                readMux[VC_NOISE_LSB +: 3] = s.vcfg.noiseAmp;
            end
            VOICE_ACTIVITY_STATUS_OFS: readMux[VS_TX_VOICE_BIT] = s.voxDetect;
            default: readMux = 32'h0000_0000;
        endcase
    endfunction : readMux

    // ************************************************************
    // State
    // ************************************************************
    ecp_state_s r;
    ecp_state_s n;
    logic accept;
    logic rxVoiceNow;
    logic [15:0] noise;
    logic [3:0] noiseShift;

    always_comb
    begin
        n = r;
        accept = hsel && hready && htrans[1];
        rxVoiceNow = 1'b0;
        noise = 16'h0000;
        noiseShift = 4'h0;

        // Two flops per pin; the first stage feeds only the second
        n.lineA = linePins;
        n.lineB = r.lineA;
        n.acA = acousticPins;
        n.acB = r.acA;
        n.miscA = miscPins;
        n.miscB = r.miscA;

        // Write data phase; hreadyout never drops so it always completes here
        if (r.wrPend)
        begin
            case (r.wrAddr)
                MUTE_CONFIG_OFS: n.muteCfg = hwdata[MC_LEVEL_LSB +: 3];
                VOICE_ACTIVITY_CONFIG_OFS:
                begin
                    n.vcfg.voxEn = hwdata[VC_VOX_EN_BIT];
                    n.vcfg.voxThrSel = hwdata[VC_THR_LSB +: 2];
                    n.vcfg.rxVoice = hwdata[VC_RX_VOICE_BIT];
                    n.vcfg.noiseAmp = hwdata[VC_NOISE_LSB +: 3];
                end
                default: n.muteCfg = r.muteCfg;
            endcase
        end

        // Pin settings only take effect on a frame edge so a sample never sees a mix
        if (frameSync)
        begin
            n.lineAp = r.lineB;
            n.acAp = r.acB;
            n.miscAp = r.miscB;
            n.lineCtl = chanCtl(n.lineAp, lineSmp);
            n.acCtl = chanCtl(n.acAp, acousticSmp);
            n.muteActive = n.miscAp.muteEn;
            n.muteLevel = n.miscAp.muteEn ? (n.miscAp.muteLevelSel | n.muteCfg) : 3'h0;
            n.voxDetect = magOf(lineSmp.sendInput) > voxThresh(n.vcfg.voxThrSel);
            n.txVoiceActiveOut = n.vcfg.voxEn && n.voxDetect;
            n.lfsr = {r.lfsr[14:0], r.lfsr[15] ^ r.lfsr[13] ^ r.lfsr[12] ^ r.lfsr[10]};
            rxVoiceNow = n.miscAp.rxVoiceActiveIn || n.vcfg.rxVoice;
            noiseShift = NOISE_SHIFT_BASE - {1'b0, n.vcfg.noiseAmp};
            noise = 16'($signed(r.lfsr) >>> noiseShift);
            n.rxPathOut = rxVoiceNow ? acousticPcmIn : noise;
        end

        // Address phase; read data is registered so it stands in the data phase
        n.wrPend = accept && hwrite;
        n.wrAddr = haddr[7:0];
        n.hrdata = (accept && !hwrite) ? readMux(haddr[7:0], n) : 32'h0000_0000;
        n.hreadyout = 1'b1;
        n.hresp = 1'b0;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            r <= ECP_STATE_RST;
        end
        else
        begin
            r <= n;
        end
    end

    assign hreadyout = r.hreadyout;
    assign hresp = r.hresp;
    assign hrdata = r.hrdata;
    assign lineCtl = r.lineCtl;
    assign acousticCtl = r.acCtl;
    assign muteActive = r.muteActive;
    assign muteLevel = r.muteLevel;
    assign txVoiceActiveOut = r.txVoiceActiveOut;
    assign rxPathOut = r.rxPathOut;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_coef1_clear_line: assert property (
        (!linePins.coef1ClearN) [*3] ##0 frameSync |=> lineCtl.coef1Clear)
        else $error("line coefficient set one not cleared");
    a_coef2_clear_ac: assert property (
        (!acousticPins.coef2ClearN) [*3] ##0 frameSync |=> acousticCtl.coef2Clear)
        else $error("acoustic coefficient set two not cleared");
    a_howl_detect_on: assert property (
        (linePins.howlDetectEn) [*3] ##0 frameSync |=> lineCtl.howlDetect)
        else $error("howling detection not enabled");
    a_center_clip_min: assert property (
        (acousticPins.centerClipEn) [*3] ##0 (frameSync && acousticSmp.sendOutput == 16'hfffc)
        |=> acousticCtl.sendOutClipped == 16'h0001)
        else $error("center clip did not force minimum code");
    a_coef_freeze_on: assert property (
        (acousticPins.coefFreeze) [*3] ##0 frameSync |=> acousticCtl.coefFreeze)
        else $error("coefficients not frozen");
    a_send_atten_sel: assert property (
        (!linePins.attenOff) [*3] ##0
        (frameSync && lineSmp.sendInput == 16'h0000 && lineSmp.receiveInput == 16'h7fff)
        |=> lineCtl.sendAtten && !lineCtl.recvAtten)
        else $error("send attenuator not selected");
    a_recv_atten_sel: assert property (
        (!linePins.attenOff) [*3] ##0 (frameSync && lineSmp.sendInput == 16'h0100)
        |=> lineCtl.recvAtten && !lineCtl.sendAtten)
        else $error("receive attenuator not selected");
    a_gain_range_max: assert property (
        lineCtl.gainAttenHalfDb <= 5'h11 && acousticCtl.gainAttenHalfDb <= 5'h11)
        else $error("gain control beyond 8.5 dB");
    a_gain_below_onset: assert property (
        frameSync && magOf(lineSmp.receiveInput) < 16'h016e |=> lineCtl.gainAttenHalfDb == 5'h00)
        else $error("gain control active below onset");
    a_mute_needs_en: assert property (
        (!miscPins.muteEn) [*3] ##0 frameSync |=> muteLevel == 3'h0 && !muteActive)
        else $error("mute applied without enable");
    a_mute_level_or: assert property (
        (miscPins.muteEn && miscPins.muteLevelSel == 3'h1) [*3] ##0 frameSync
        |=> muteLevel == (3'h1 | r.muteCfg))
        else $error("mute level not ORed");
    a_out_gain_pad: assert property (
        (linePins.outGainPad == 3'h7) [*3] ##0 frameSync |=> lineCtl.outGainDb == 4'he)
        else $error("output gain pad wrong");
    a_in_loss_pad: assert property (
        (acousticPins.inLossPad == 3'h3) [*3] ##0 frameSync |=> acousticCtl.inLossDb == 4'h6)
        else $error("input loss pad wrong");
    a_vox_needs_en: assert property (
        frameSync && !n.vcfg.voxEn |=> !txVoiceActiveOut)
        else $error("voice activity out without enable");
    a_vox_detect_loud: assert property (
        frameSync && n.vcfg.voxEn && lineSmp.sendInput == 16'hfeff |=> txVoiceActiveOut)
        else $error("loud voice not detected");
    a_vox_status_mirror: assert property (
        txVoiceActiveOut |-> r.voxDetect)
        else $error("status bit does not mirror voice activity");
    a_vox_threshold_sel: assert property (
        frameSync && n.vcfg.voxThrSel == 2'h3 && lineSmp.sendInput == 16'h0100 |=> !r.voxDetect)
        else $error("threshold field ignored");
    a_rx_voice_pass: assert property (
        (miscPins.rxVoiceActiveIn) [*3] ##0 frameSync |=> rxPathOut == $past(acousticPcmIn))
        else $error("acoustic input not passed");
    a_rx_voice_reg_or: assert property (
        frameSync && n.vcfg.rxVoice |=> rxPathOut == $past(acousticPcmIn))
        else $error("register voice bit not ORed");
    a_frame_aligned: assert property (
        !frameSync |=> $stable(lineCtl) && $stable(acousticCtl) && $stable(muteLevel))
        else $error("control changed between frames");

    c_vox_active: cover property (frameSync ##1 txVoiceActiveOut);
    c_mute_applied: cover property (frameSync ##1 muteActive && muteLevel != 3'h0);
    c_clip_forced: cover property (frameSync ##1 lineCtl.sendOutClipped == 16'h0001);
    c_noise_out: cover property (frameSync && !rxVoiceNow);

endmodule : ecp_pin_control

// ===== hw/ecp_pkg.sv
package ecp_pkg;

    // ************************************************************
    // Register map and field layout
    // ************************************************************
    localparam logic [7:0] MUTE_CONFIG_OFS = 8'h00;
    localparam logic [7:0] VOICE_ACTIVITY_CONFIG_OFS = 8'h04;
    localparam logic [7:0] VOICE_ACTIVITY_STATUS_OFS = 8'h08;
    localparam int VC_VOX_EN_BIT = 7;
    localparam int VC_THR_LSB = 5;
    localparam int VC_RX_VOICE_BIT = 3;
    localparam int VC_NOISE_LSB = 0;
    localparam int VS_TX_VOICE_BIT = 7;
    localparam int MC_LEVEL_LSB = 0;

    // ************************************************************
    // Signal levels on 16-bit linear samples
    // ************************************************************
    // Center clip threshold, about -57 dBm0
    localparam logic [15:0] CLIP_THRESH_LIN = 16'h0008;
    localparam logic [15:0] CLIP_MIN_POS = 16'h0001;
    localparam logic [15:0] SIG_PRESENT_LIN = 16'h0040;
    // Gain control onset, about -24 dBm0
    localparam logic [15:0] GC_ONSET_LIN = 16'h016e;
    localparam logic [3:0] GC_ONSET_IDX = 4'h8;
    localparam logic [7:0] GC_HALFDB_PER_OCT = 8'h06;
    // 8.5 dB in half-dB steps
    localparam logic [7:0] GC_MAX_HALFDB = 8'h11;
    localparam logic [15:0] VOX_THR_0 = 16'h0020;
    localparam logic [15:0] VOX_THR_1 = 16'h0040;
    localparam logic [15:0] VOX_THR_2 = 16'h0080;
    localparam logic [15:0] VOX_THR_3 = 16'h0100;
    localparam logic [3:0] NOISE_SHIFT_BASE = 4'ha;
    localparam logic [15:0] LFSR_SEED = 16'hace1;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic coef1ClearN;
        logic coef2ClearN;
        logic howlDetectEn;
        logic centerClipEn;
        logic coefFreeze;
        logic attenOff;
        logic gainCtrlEn;
        logic [2:0] outGainPad;
        logic [2:0] inLossPad;
    } ecp_chan_pins_s;

    typedef struct packed {
        logic muteEn;
        logic [2:0] muteLevelSel;
        logic rxVoiceActiveIn;
    } ecp_misc_pins_s;

    typedef struct packed {
        logic [15:0] sendInput;
        logic [15:0] receiveInput;
        logic [15:0] sendOutput;
    } ecp_chan_smp_s;

    typedef struct packed {
        logic coef1Clear;
        logic coef2Clear;
        logic howlDetect;
        logic coefFreeze;
        logic sendAtten;
        logic recvAtten;
        logic [4:0] gainAttenHalfDb;
        logic [3:0] outGainDb;
        logic [3:0] inLossDb;
        logic [15:0] sendOutClipped;
    } ecp_chan_ctl_s;

    typedef struct packed {
        logic voxEn;
        logic [1:0] voxThrSel;
        logic rxVoice;
        logic [2:0] noiseAmp;
    } ecp_vcfg_s;

    typedef struct packed {
        ecp_chan_pins_s lineA, lineB, lineAp;
        ecp_chan_pins_s acA, acB, acAp;
        ecp_misc_pins_s miscA, miscB, miscAp;
        logic [2:0] muteCfg;
        ecp_vcfg_s vcfg;
        logic wrPend;
        logic [7:0] wrAddr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        ecp_chan_ctl_s lineCtl;
        ecp_chan_ctl_s acCtl;
        logic muteActive;
        logic [2:0] muteLevel;
        logic voxDetect;
        logic txVoiceActiveOut;
        logic [15:0] rxPathOut;
        logic [15:0] lfsr;
    } ecp_state_s;

    localparam ecp_state_s ECP_STATE_RST = '{hreadyout: 1'b1, lfsr: LFSR_SEED, default: '0};

endpackage : ecp_pkg
